/* logic/pcix_cap_pkg.sv */
// Purpose: shared constants and carriers for the pci-x capability and status bank
// Assumes: byte offsets within configuration space, dword aligned accesses
// Notes:   status bit positions follow the secondary status dword at 0x80
`default_nettype none
package pcix_cap_pkg;

  // register offsets (byte addresses in configuration space)
  localparam logic [7:0]  OFS_OPAQUE_EN      = 8'h70;
  localparam logic [7:0]  OFS_OPAQUE_LIM_HI  = 8'h7C;
  localparam logic [7:0]  OFS_PCIX_CAP       = 8'h80;

  // reset values and fixed read values
  localparam logic [31:0] RST_OPAQUE_LIM_HI  = 32'hFFFF_FFFF;
  localparam logic [7:0]  CAP_ID_PCIX        = 8'h07;
  localparam logic [7:0]  CAP_NEXT_PTR       = 8'h90;
  localparam logic [7:0]  SEC_DEV_NUM        = 8'h00;
  localparam logic [2:0]  SEC_FUNC_NUM       = 3'h0;
  localparam logic [2:0]  RST_CLK_FREQ       = 3'h0;
  localparam logic [19:0] LIMIT_LOW_FILL     = 20'hF_FFFF;

  // field positions in the capability dword, plus bit 0 of the opaque enable dword
  localparam int          POS_CAP_ID         = 0;
  localparam int          POS_NEXT_PTR       = 8;
  localparam int          POS_WIDE_BUS       = 16;
  localparam int          POS_CAP_133        = 17;
  localparam int          POS_CPL_DISCARD    = 18;
  localparam int          POS_UNEXP_CPL      = 19;
  localparam int          POS_CPL_OVERRUN    = 20;
  localparam int          POS_SPLIT_DELAYED  = 21;
  localparam int          POS_CLK_FREQ       = 22;
  localparam int          POS_OPAQUE_EN      = 0;

  // sticky split event flags, msb is bit 21
  typedef struct packed {
    logic split_delayed;
    logic cpl_overrun;
    logic unexp_cpl;
    logic cpl_discard;
  } split_flags_t;

  // one configuration access
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_t;

  // byte-lane merge for a writable dword
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage
`default_nettype wire

/* logic/opaque_range_check.sv */
// Purpose: inclusive compare of a 64-bit address against the opaque window
// Assumes: base and limit already assembled to full 64-bit addresses
// Notes:   purely combinational, registered by the caller
`timescale 1ns/100ps
`default_nettype none
module opaque_range_check (
  input  wire logic        i_enable,
  input  wire logic [63:0] i_addr,
  input  wire logic [63:0] i_base,
  input  wire logic [63:0] i_limit,
  output logic             o_hit
);
  // an inverted window (base above limit) never hits
  assign o_hit = i_enable && (i_addr >= i_base) && (i_addr <= i_limit);
endmodule
`default_nettype wire

/* logic/pcix_capability_status_regs.sv */
// Purpose: opaque limit upper dword, opaque enable, pci-x capability entry and secondary status
// Assumes: config accesses are single-cycle strobes, synchronous to i_clk_sys
// Notes:   event inputs are one-cycle pulses from the bridge data path
`timescale 1ns/100ps
`default_nettype none
// Operation
// - limit upper dword is read-write, all ones after reset.
// - memory requests inside opaque base-to-limit range are refused on both sides.
// - opaque range acts only when enabled; enable clears at reset and loads from strap on the first clock after release.
// - capability id byte always reads 07h.
// - next pointer byte always reads 90h.
// - bits 24:22 report secondary clock code chosen at secondary reset.
// - bit 21 sets on downstream split request delayed; clears at reset.
// - bit 20 sets on secondary split completion overrun; clears at reset.
// - bit 19 sets on unexpected completion to our secondary id; clears at reset.
// - bit 18 sets on discarded completion toward secondary; clears at reset.
// - bit 17 always reads 1.
// - bit 16 reads 1 when secondary path 64-bit and strap high.
// - bits 31:25 read zero.
module pcix_capability_status_regs
  import pcix_cap_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_arst_n,
  // configuration access from the primary bus
  input  wire cfg_req_t    i_cfg,
  output logic [31:0]      o_cfg_rdata,
  output logic             o_cfg_ack,
  // straps and secondary-side state
  input  wire logic        i_opaque_en_strap,
  input  wire logic        i_wide_bus_strap_n,
  input  wire logic        i_sec_path_64,
  input  wire logic        i_sec_rst_active,
  input  wire logic [2:0]  i_sec_clk_freq,
  // neighbouring opaque registers
  input  wire logic [63:20] i_opaque_base,
  input  wire logic [11:0] i_opaque_limit_low,
  // memory claim checks
  input  wire logic        i_pri_mem_req,
  input  wire logic [63:0] i_pri_mem_addr,
  input  wire logic        i_sec_mem_req,
  input  wire logic [63:0] i_sec_mem_addr,
  output logic             o_pri_refuse,
  output logic             o_sec_refuse,
  // split transaction events
  input  wire logic        i_evt_split_delayed,
  input  wire logic        i_evt_cpl_overrun,
  input  wire logic        i_evt_cpl_discard,
  input  wire logic        i_sec_cpl_valid,
  input  wire logic [15:0] i_sec_cpl_req_id,
  input  wire logic        i_sec_cpl_outstanding,
  input  wire logic [7:0]  i_sec_bus_num
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [31:0]   lim_hi_q;
  logic          opaque_en_q;
  logic          strap_taken_q;
  logic [2:0]    clk_freq_q;
  split_flags_t  flags_q;
  split_flags_t  flags_set;
  split_flags_t  flags_clr;
  logic          hit_pri;
  logic          hit_sec;
  logic          unexp_hit;
  logic          wr_lim;
  logic          wr_en;
  logic          wr_cap;
  logic [63:0]   lim_full;
  logic [63:0]   base_full;
  logic [31:0]   cap_word;

  assign wr_lim = i_cfg.wr && (i_cfg.addr[7:2] == OFS_OPAQUE_LIM_HI[7:2]);
  assign wr_en  = i_cfg.wr && (i_cfg.addr[7:2] == OFS_OPAQUE_EN[7:2]);
  assign wr_cap = i_cfg.wr && (i_cfg.addr[7:2] == OFS_PCIX_CAP[7:2]);

  ////////////////////////////////////////////////////////////////////////////
  // opaque limit upper dword
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lim_hi_q <= RST_OPAQUE_LIM_HI;
    end else if (wr_lim) begin
      lim_hi_q <= merge_be(lim_hi_q, i_cfg.wdata, i_cfg.be);
    end
  end

  // enable bit; strap is caught on the first edge after release, not in reset
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      opaque_en_q   <= 1'b0;
      strap_taken_q <= 1'b0;
    end else begin
      strap_taken_q <= 1'b1;
      if (!strap_taken_q) begin
        opaque_en_q <= i_opaque_en_strap;
      end else if (wr_en && i_cfg.be[0]) begin
        opaque_en_q <= i_cfg.wdata[POS_OPAQUE_EN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // claim refusal on both interfaces
  assign base_full = {i_opaque_base, 20'h0_0000};
  assign lim_full  = {lim_hi_q, i_opaque_limit_low, LIMIT_LOW_FILL};

  opaque_range_check u_chk_pri (
    .i_enable (opaque_en_q),
    .i_addr   (i_pri_mem_addr),
    .i_base   (base_full),
    .i_limit  (lim_full),
    .o_hit    (hit_pri)
  );

  opaque_range_check u_chk_sec (
    .i_enable (opaque_en_q),
    .i_addr   (i_sec_mem_addr),
    .i_base   (base_full),
    .i_limit  (lim_full),
    .o_hit    (hit_sec)
  );

  // one cycle of latency keeps outputs straight from flops
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pri_refuse <= 1'b0;
      o_sec_refuse <= 1'b0;
    end else begin
      o_pri_refuse <= i_pri_mem_req && hit_pri;
      o_sec_refuse <= i_sec_mem_req && hit_sec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // secondary clock code, held at the value chosen while secondary reset is driven
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clk_freq_q <= RST_CLK_FREQ;
    end else if (i_sec_rst_active) begin
      clk_freq_q <= i_sec_clk_freq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // split event flags
  assign unexp_hit = i_sec_cpl_valid && !i_sec_cpl_outstanding &&
                     (i_sec_cpl_req_id == {i_sec_bus_num, SEC_DEV_NUM[4:0], SEC_FUNC_NUM});

  assign flags_set = '{split_delayed: i_evt_split_delayed,
                       cpl_overrun:   i_evt_cpl_overrun,
                       unexp_cpl:     unexp_hit,
                       cpl_discard:   i_evt_cpl_discard};
  assign flags_clr = (wr_cap && i_cfg.be[2]) ?
                     split_flags_t'(i_cfg.wdata[POS_SPLIT_DELAYED:POS_CPL_DISCARD]) : '0;

  // set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~flags_clr) | flags_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  always_comb begin
    cap_word = '0;
    cap_word[POS_CAP_ID +: 8]   = CAP_ID_PCIX;
    cap_word[POS_NEXT_PTR +: 8] = CAP_NEXT_PTR;
    cap_word[POS_WIDE_BUS]      = i_sec_path_64 && i_wide_bus_strap_n;
    cap_word[POS_CAP_133]       = 1'b1;
    cap_word[POS_SPLIT_DELAYED:POS_CPL_DISCARD] = flags_q;
    cap_word[POS_CLK_FREQ +: 3] = clk_freq_q;
  end

  // unmapped dwords read zero; every access is acked one cycle later
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cfg_rdata <= '0;
      o_cfg_ack   <= 1'b0;
    end else begin
      o_cfg_ack <= i_cfg.rd || i_cfg.wr;
      if (i_cfg.rd) begin
        case (i_cfg.addr[7:2])
          OFS_OPAQUE_EN[7:2]:     o_cfg_rdata <= {31'h0, opaque_en_q};
          OFS_OPAQUE_LIM_HI[7:2]: o_cfg_rdata <= lim_hi_q;
          OFS_PCIX_CAP[7:2]:      o_cfg_rdata <= cap_word;
          default:                o_cfg_rdata <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic rd_cap_q;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_cap_q <= 1'b0;
    end else begin
      rd_cap_q <= i_cfg.rd && (i_cfg.addr[7:2] == OFS_PCIX_CAP[7:2]);
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  a_limit_write: assert property (wr_lim && i_cfg.be == 4'hF |=> lim_hi_q == $past(i_cfg.wdata))
    else $error("limit upper dword not written");
  a_refuse_inside: assert property (i_pri_mem_req && opaque_en_q && i_pri_mem_addr >= base_full &&
                                    i_pri_mem_addr <= lim_full |=> o_pri_refuse)
    else $error("primary request in window not refused");
  a_refuse_off: assert property (!opaque_en_q |=> !o_sec_refuse)
    else $error("refusal while window disabled");
  a_cap_ids: assert property (rd_cap_q |-> o_cfg_rdata[15:0] == 16'h9007)
    else $error("capability id or next pointer wrong");
  a_next_ptr: assert property (rd_cap_q |-> o_cfg_rdata[15:8] == CAP_NEXT_PTR)
    else $error("next pointer wrong");
  a_reserved_zero: assert property (rd_cap_q |-> o_cfg_rdata[31:25] == 7'h00 && o_cfg_rdata[17])
    else $error("reserved bits or 133 capable bit wrong");
  a_unexp_set: assert property (unexp_hit |=> flags_q.unexp_cpl)
    else $error("unexpected completion not flagged");
  a_set_wins: assert property (i_evt_split_delayed && flags_clr.split_delayed |=> flags_q.split_delayed)
    else $error("event lost during clear");
  a_w1c_clear: assert property (flags_clr.cpl_overrun && !i_evt_cpl_overrun |=> !flags_q.cpl_overrun)
    else $error("flag not cleared by write of one");
  a_zero_keep: assert property (wr_cap && i_cfg.be[2] && flags_q.cpl_discard &&
                                !i_cfg.wdata[POS_CPL_DISCARD] |=> flags_q.cpl_discard)
    else $error("write of zero cleared flag");
  a_freq_hold: assert property (!i_sec_rst_active |=> clk_freq_q == $past(clk_freq_q))
    else $error("clock code changed outside secondary reset");
  a_overrun_set: assert property (i_evt_cpl_overrun |=> flags_q.cpl_overrun)
    else $error("overrun not flagged");

  c_refuse_pri: cover property (o_pri_refuse);
  c_flag_clear: cover property (flags_q.unexp_cpl ##1 !flags_q.unexp_cpl);
  c_cap_read:   cover property (rd_cap_q && o_cfg_rdata[POS_WIDE_BUS]);

endmodule
`default_nettype wire

/* testbench/cfg_host_model.sv */
// Purpose: configuration host on the primary bus, one strobe access at a time
// Assumes: xfer is entered just after a falling edge
// Notes:   a released bus shows inverted values so stale data never looks valid
`timescale 1ns/100ps
`default_nettype none
module cfg_host_model
  import pcix_cap_pkg::*;
(
  input  wire logic        i_clk_sys,
  output var cfg_req_t     o_cfg,
  input  wire logic [31:0] i_cfg_rdata,
  input  wire logic        i_cfg_ack
);
  // quiet bus until the first access
  initial o_cfg = '0;
  // strobe for one edge, take ack and data in the cycle after it
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] d, output logic [31:0] q, output logic k);
    o_cfg = {w, ~w, a, be, d};
    @(negedge i_clk_sys);
    q = i_cfg_rdata;
    k = i_cfg_ack;
    o_cfg = {2'b00, ~a, ~be, ~d};
    // one idle edge so strobes never merge
    @(negedge i_clk_sys);
  endtask
endmodule
`default_nettype wire

/* testbench/pcix_capability_status_regs_tb.sv */
// Purpose: self-checking bench for the capability and status bank
// Assumes: inputs change at the falling edge, seed fixed
// Notes:   expected words built locally, never read back from the design
`timescale 1ns/100ps
`default_nettype none
module pcix_capability_status_regs_tb;
  import pcix_cap_pkg::*;
  logic        i_clk_sys, i_arst_n, strap, wide_n, path64, sec_rst, cpl_valid, cpl_out;
  logic        pri_req, sec_req, ev_sd, ev_ov, ev_dc, pri_ref, sec_ref, ack;
  logic [2:0]  freq;
  logic [15:0] req_id;
  logic [7:0]  bus_num;
  logic [43:0] base;
  logic [11:0] lim_lo;
  logic [63:0] pri_addr, sec_addr, base_a, lim_a;
  logic [31:0] rdata, q, lim, d;
  logic [3:0]  be;
  cfg_req_t    cfg;
  int          n_fail, tests_run, seed;

  pcix_capability_status_regs pcix_capability_status_regs_inst (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_cfg(cfg), .o_cfg_rdata(rdata), .o_cfg_ack(ack),
    .i_opaque_en_strap(strap), .i_wide_bus_strap_n(wide_n), .i_sec_path_64(path64),
    .i_sec_rst_active(sec_rst), .i_sec_clk_freq(freq), .i_opaque_base(base), .i_opaque_limit_low(lim_lo),
    .i_pri_mem_req(pri_req), .i_pri_mem_addr(pri_addr), .i_sec_mem_req(sec_req), .i_sec_mem_addr(sec_addr),
    .o_pri_refuse(pri_ref), .o_sec_refuse(sec_ref), .i_evt_split_delayed(ev_sd), .i_evt_cpl_overrun(ev_ov),
    .i_evt_cpl_discard(ev_dc), .i_sec_cpl_valid(cpl_valid), .i_sec_cpl_req_id(req_id),
    .i_sec_cpl_outstanding(cpl_out), .i_sec_bus_num(bus_num));
  cfg_host_model cfg_host_model_inst (
    .i_clk_sys(i_clk_sys), .o_cfg(cfg), .i_cfg_rdata(rdata), .i_cfg_ack(ack));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // expected capability dword
  function automatic logic [31:0] cap(input logic [2:0] c, input logic [3:0] f, input logic w);
    return {7'h00, c, f, 1'b1, w, 8'h90, 8'h07};
  endfunction
  // byte-lane merge kept apart from the package copy
  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n, input logic [3:0] m);
    for (int i = 0; i < 4; i++) begin
      if (m[i]) begin
        o[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return o;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [3:0] m, input logic [31:0] v);
    logic k;
    cfg_host_model_inst.xfer(1'b1, a, m, v, q, k);
    chk(k, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic k;
    cfg_host_model_inst.xfer(1'b0, a, 4'hF, 32'h0000_0000, q, k);
    chk(k, 1'b1);
    chk(q, e);
  endtask
  task automatic reset(input logic s);
    i_arst_n = 1'b0;
    strap = s;
    repeat (2) @(negedge i_clk_sys);
    i_arst_n = 1'b1;
    // strap taken at edge 1, first access sampled at edge 3
    repeat (2) @(negedge i_clk_sys);
  endtask
  // one-cycle event pulse, k picks the flag from bit 21 down
  task automatic pulse(input int k);
    {ev_sd, ev_ov, cpl_valid, ev_dc} = 4'b1000 >> k;
    @(negedge i_clk_sys);
    {ev_sd, ev_ov, cpl_valid, ev_dc} = 4'h0;
    // idle edge so a following pulse never re-raises in the same step
    @(negedge i_clk_sys);
  endtask
  // same address on both sides, refusal seen one cycle later
  task automatic probe(input logic [63:0] a, input logic e);
    {pri_req, sec_req, pri_addr, sec_addr} = {2'b11, a, a};
    @(negedge i_clk_sys);
    {pri_req, sec_req, pri_addr, sec_addr} = {2'b00, ~a, ~a};
    chk(pri_ref, e);
    chk(sec_ref, e);
    // idle edge between probes keeps each request a separate cycle
    @(negedge i_clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    #(20 * 20000);
    n_fail++;
    conclude();
  end
  // main sequence
  initial begin
    seed = 51477;
    {i_arst_n, strap, wide_n, path64, sec_rst, cpl_valid, cpl_out} = '0;
    {pri_req, sec_req, ev_sd, ev_ov, ev_dc, freq, pri_addr, sec_addr} = '0;
    {bus_num, base, lim_lo} = {8'h5A, 44'h000_1000_0000, 12'h000};
    req_id = {bus_num, 8'h00};
    reset(1'b0);
    rd(8'h7C, 32'hFFFF_FFFF);
    rd(8'h80, cap(3'h0, 4'h0, 1'b0));
    rd(8'h40, 32'h0000_0000);
    rd(8'h70, 32'h0000_0000);
    // model starts from the reset value, unwritten lanes keep it
    lim = 32'hFFFF_FFFF;
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      be = 4'($random(seed));
      wr(8'h7C, be, d);
      lim = mrg(lim, d, be);
      rd(8'h7C, lim);
    end
    // limit upper dword above the base upper dword, so the window is not inverted
    lim = 32'h0002_0000;
    wr(8'h7C, 4'hF, lim);
    wr(8'h80, 4'hF, 32'hFFFF_FFFF);
    rd(8'h80, cap(3'h0, 4'h0, 1'b0));
    base_a = {base, 20'h0_0000};
    lim_a = {lim, lim_lo, 20'hF_FFFF};
    probe(base_a, 1'b0);
    wr(8'h70, 4'h1, 32'h0000_0001);
    rd(8'h70, 32'h0000_0001);
    probe(base_a - 1, 1'b0);
    probe(base_a, 1'b1);
    probe(lim_a, 1'b1);
    probe(lim_a + 1, 1'b0);
    probe(base_a + 64'($unsigned($random(seed))), 1'b1);
    wr(8'h70, 4'h1, 32'h0000_0000);
    probe(lim_a, 1'b0);
    // wide-bus bit follows path width and strap live
    for (int i = 0; i < 4; i++) begin
      {path64, wide_n} = i[1:0];
      rd(8'h80, cap(3'h0, 4'h0, path64 & wide_n));
    end
    // clock code frozen when secondary reset drops
    for (int c = 0; c < 4; c++) begin
      {sec_rst, freq} = {1'b1, c[2:0]};
      @(negedge i_clk_sys);
      {sec_rst, freq} = {1'b0, 3'h4};
      @(negedge i_clk_sys);
      rd(8'h80, cap(c[2:0], 4'h0, 1'b1));
    end
    // each flag sets, survives a zero write, clears on a one
    for (int k = 0; k < 4; k++) begin
      pulse(k);
      rd(8'h80, cap(3'h3, 4'b1000 >> k, 1'b1));
      wr(8'h80, 4'h4, 32'h0000_0000);
      rd(8'h80, cap(3'h3, 4'b1000 >> k, 1'b1));
      wr(8'h80, 4'h4, 32'h0000_0001 << (21 - k));
      rd(8'h80, cap(3'h3, 4'h0, 1'b1));
    end
    // completions that are outstanding or for another device stay quiet
    cpl_out = 1'b1;
    pulse(2);
    {cpl_out, req_id} = {1'b0, bus_num, 8'h08};
    pulse(2);
    rd(8'h80, cap(3'h3, 4'h0, 1'b1));
    pulse(0);
    reset(1'b1);
    rd(8'h80, cap(3'h0, 4'h0, 1'b1));
    rd(8'h7C, 32'hFFFF_FFFF);
    rd(8'h70, 32'h0000_0001);
    probe(base_a, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
